// ==== bench/tb_top.sv ====
// Purpose : self-checking bench for trsp_result_port
// Assumes : receivers watch channels 0 and 3
// Notes   : sync stamp fixed at 16, calibration 7 on channel 0
`include "trsp_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [127:0] ARM_TT = 128'hfefcfcee80c0a088f0ccaa;
  logic         ref_clk, rstn, reg_wr, reg_rd, ddr, fourth_arm_ok_ff, rclk_ff;
  logic [2:0]   abc;
  logic [3:0]   reg_addr, cap_valid, rstrobe_n_ff, rdata_ff;
  logic [31:0]  reg_wdata, reg_rdata_ff, v;
  logic [159:0] cap_stamp;
  logic [39:0]  sync_stamp;
  logic [63:0]  w0, w3;
  int           l0, f0, f3, n_errors, checks;
  wire          first_event_channel_armed = abc[0];
  wire          second_event_channel_armed = abc[1];
  wire          third_event_channel_armed = abc[2];

  trsp_result_port u_dut (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata_ff, .first_event_channel_armed,
    .second_event_channel_armed, .third_event_channel_armed,
    .fourth_arm_ok_ff, .cap_valid, .cap_stamp, .sync_stamp, .rclk_ff,
    .rstrobe_n_ff, .rdata_ff);
  trsp_rx_model #(.CH(0)) u_rx0 (.ref_clk, .rclk(rclk_ff), .ddr,
    .strobe_n(rstrobe_n_ff), .data(rdata_ff), .word(w0), .len(l0), .nfr(f0));
  trsp_rx_model #(.CH(3)) u_rx3 (.ref_clk, .rclk(rclk_ff), .ddr,
    .strobe_n(rstrobe_n_ff), .data(rdata_ff), .word(w3), .len(), .nfr(f3));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ==========================================================================
  // helpers
  task automatic results;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic give_up(input logic ok);
    if (!ok) begin
      n_errors++;
      results();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata_ff;
  endtask
  task automatic wait_rx(input int a, input int b);
    int i;
    for (i = 0; i < 20000 && (f0 < a || f3 < b); i++)
      step();
    give_up(f0 >= a && f3 >= b);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset;
    rd(`TRSP_ADDR_CTRL);
    chk(v, `TRSP_CTRL_RST);
    rd(`TRSP_ADDR_STAT);
    chk(v, 32'hf0);
    rd(4'hf);
    chk(v, 32'h0);
    wr(`TRSP_ADDR_CAL0, 32'h7);
    rd(`TRSP_ADDR_CAL0);
    chk(v, 32'h7);
  endtask
  task automatic t_arm;
    for (int s = 0; s < 16; s++)
      for (int c = 0; c < 8; c++) begin
        wr(`TRSP_ADDR_CTRL, {20'h0, s[3:0], 8'h04});
        abc <= c[2:0];
        cyc(3);
        #1;
        chk(fourth_arm_ok_ff, ARM_TT[s * 8 + c]);
      end
  endtask
  task automatic t_rate;
    int i, t1, pr;
    logic p;
    for (int r = 0; r < 4; r++)
      for (int d = 0; d < 2; d++) begin
        wr(`TRSP_ADDR_CTRL, {26'h0, d[0], r[1:0], 3'h4});
        cyc(400);
        pr = 0;
        t1 = -1;
        p  = 1'b1;
        for (i = 0; i < 60; i++) begin
          step();
          if (rclk_ff && !p && t1 >= 0 && pr == 0)
            pr = i - t1;
          if (rclk_ff && !p)
            t1 = i;
          p = rclk_ff;
        end
        chk(pr, (r == 2 ? 2 : r == 1 ? 4 : 8) * (d + 1));
      end
  endtask
  task automatic t_frame(input logic [2:0] lc, input logic [1:0] rc,
                         input logic dd);
    int n;
    logic [63:0] m;
    n = (lc + 1) * 8;
    m = (64'h1 << n) - 64'h1;
    wr(`TRSP_ADDR_CTRL, {26'h0, dd, rc, lc});
    ddr <= dd;
    cyc(400);
    cap_stamp <= {40'h6a, 80'h0, 40'h0};
    cap_valid <= 4'h9;
    cyc(1);
    cap_valid <= 4'h0;
    wait_rx(f0 + 1, f3 + 1);
    chk(w0, (64'h0 - 64'd9) & m);
    chk(w3, 64'h5a & m);
    chk(l0, n);
  endtask
  task automatic t_fifo;
    int i, n;
    wr(`TRSP_ADDR_CTRL, 32'h4);
    ddr <= 1'b0;
    abc <= 3'h0;
    cyc(400);
    cap_stamp[39:0] <= 40'h20;
    cap_valid <= 4'h1;
    cyc(1);
    cap_valid <= 4'h0;
    n = f0;
    for (i = 0; i < 800 && rstrobe_n_ff[0] !== 1'b0; i++)
      step();
    give_up(i < 800);
    cyc(1);
    for (i = 1; i < 18; i++) begin
      cap_stamp[39:0] <= 40'h20 + i;
      cap_valid <= 4'h1;
      cyc(1);
    end
    cap_valid <= 4'h0;
    rd(`TRSP_ADDR_STAT);
    chk(v, 32'he1);
    wait_rx(n + 16, f3);
    chk(w0, 64'h26);
    rd(`TRSP_ADDR_STAT);
    chk(v, 32'hf0);
    cyc(800);
    chk(f0, n + 16);
  endtask

  initial begin
    rstn       = 1'b0;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_addr   = 4'h0;
    reg_wdata  = 32'h0;
    cap_valid  = 4'h0;
    cap_stamp  = 160'h0;
    sync_stamp = 40'h10;
    abc        = 3'h0;
    ddr        = 1'b0;
    n_errors   = 0;
    checks     = 0;
    cyc(2);
    rstn <= 1'b1;
    t_reset();
    t_arm();
    t_rate();
    for (int l = 0; l < 5; l++)
      t_frame(l[2:0], 2'h2, 1'b0);
    t_frame(3'h1, 2'h1, 1'b1);
    t_fifo();
    results();
  end
endmodule // tb_top

bind trsp_result_port trsp_chk u_chk (.ref_clk, .rstn, .reg_rd,
  .reg_rdata_ff, .rclk_ff, .rstrobe_n_ff, .rdata_ff);
`default_nettype wire

// ==== bench/trsp_chk.sv ====
// Purpose : port assertions for trsp_result_port
// Assumes : bound to the design top, one clock domain
// Notes   : frame checks use the fastest bit time of two cycles
`timescale 1ns/100ps
`default_nettype none
module trsp_chk (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata_ff,
  input wire logic        rclk_ff,
  input wire logic [3:0]  rstrobe_n_ff,
  input wire logic [3:0]  rdata_ff
);
  // ==========================================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_rst_idle: assert property (disable iff (1'b0) !rstn |=>
    rstrobe_n_ff == 4'hf && rdata_ff == 4'h0 && !rclk_ff)
    else $error("port not idle after reset");
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata_ff == 32'h0)
    else $error("read data outside read slot");
  a_marker_first: assert property ($fell(rstrobe_n_ff[0]) |-> rdata_ff[0])
    else $error("no marker bit on channel 0");
  a_marker_last: assert property ($fell(rstrobe_n_ff[3]) |-> rdata_ff[3])
    else $error("no marker bit on channel 3");
  a_gap_high: assert property ($rose(rstrobe_n_ff[0]) |-> rstrobe_n_ff[0] [*4])
    else $error("end gap too short");
  a_frame_min: assert property ($fell(rstrobe_n_ff[0]) |-> !rstrobe_n_ff[0] [*8])
    else $error("frame too short");
  a_data_edge: assert property ($changed(rdata_ff) |-> $changed(rclk_ff))
    else $error("data moved off a clock edge");
  a_strb_edge: assert property ($changed(rstrobe_n_ff) |-> $changed(rclk_ff))
    else $error("strobe moved off a clock edge");
  c_frame: cover property ($fell(rstrobe_n_ff[0]));
  c_ddr: cover property ($changed(rdata_ff) && $fell(rclk_ff));
  c_read: cover property (reg_rd ##1 reg_rdata_ff != 32'h0);
endmodule // trsp_chk
`default_nettype wire

// ==== bench/trsp_rx_model.sv ====
// Purpose : receiver for one serial result channel
// Assumes : result clock edges found by sampling on ref_clk
// Notes   : word holds the bits after the marker, first bit at 0
`timescale 1ns/100ps
`default_nettype none
module trsp_rx_model #(
  parameter int CH = 0
) (
  input  wire logic        ref_clk,
  input  wire logic        rclk,
  input  wire logic        ddr,
  input  wire logic [3:0]  strobe_n,
  input  wire logic [3:0]  data,
  output var  logic [63:0] word,
  output var  int          len,
  output var  int          nfr
);
  logic prv_ff = 1'b0;
  logic act_ff = 1'b0;
  int   k      = 0;
  initial begin
    word = 64'h0;
    len  = 0;
    nfr  = 0;
  end
  // sample on rising result clock, on both edges in double rate
  always @(posedge ref_clk) begin
    prv_ff <= rclk;
    if (rclk != prv_ff && (rclk || ddr)) begin
      if (!strobe_n[CH] && !act_ff) begin
        act_ff <= 1'b1;
        k      <= 0;
        word   <= 64'h0;
      end else if (!strobe_n[CH]) begin
        word[k] <= data[CH];
        k       <= k + 1;
      end else if (act_ff) begin
        act_ff <= 1'b0;
        len    <= k;
        nfr    <= nfr + 1;
      end
    end
  end
endmodule // trsp_rx_model
`default_nettype wire

// ==== common/trsp_defines.vh ====
// Purpose : constants for the time-stamp result serial port
// Assumes : included by verilog/trsp_result_port.v
// Notes   : register offsets are word addresses on the plain register port
`ifndef TRSP_DEFINES_VH
`define TRSP_DEFINES_VH

// ==========================================================================
// register map
`define TRSP_AW            4
`define TRSP_ADDR_CTRL     4'h0
`define TRSP_ADDR_STAT     4'h1
`define TRSP_ADDR_CAL0     4'h2
`define TRSP_ADDR_CAL3     4'h5
`define TRSP_CTRL_RST      32'h0000_0004

// ==========================================================================
// control fields
`define TRSP_LEN_MSB       2
`define TRSP_LEN_LSB       0
`define TRSP_RATE_MSB      4
`define TRSP_RATE_LSB      3
`define TRSP_DDR_BIT       5
`define TRSP_ARM_MSB       11
`define TRSP_ARM_LSB       8
`define TRSP_CAL_W         16

// ==========================================================================
// status fields
`define TRSP_ST_FULL_LSB   0
`define TRSP_ST_EMPTY_LSB  4
`define TRSP_ST_ARM_BIT    8

// ==========================================================================
// word sizes
`define TRSP_LEN_8         3'h0
`define TRSP_LEN_16        3'h1
`define TRSP_LEN_24        3'h2
`define TRSP_LEN_32        3'h3
`define TRSP_N_8           6'h08
`define TRSP_N_16          6'h10
`define TRSP_N_24          6'h18
`define TRSP_N_32          6'h20
`define TRSP_N_40          6'h28

// ==========================================================================
// bit timing in reference clock cycles per bit time
`define TRSP_RATE_MID      2'h1
`define TRSP_RATE_FAST     2'h2
`define TRSP_BITC_SLOW     4'h8
`define TRSP_BITC_MID      4'h4
`define TRSP_BITC_FAST     4'h2

// ==========================================================================
// frame and fifo
`define TRSP_W             40
`define TRSP_DEPTH         15
`define TRSP_DEPTH_IDX     6'h0f
`define TRSP_PTR_LAST      4'he
`define TRSP_CNT_FULL      5'h0f
`define TRSP_GAP_BITS      6'h02
`define TRSP_LOAD_LEAD     6'h05
`define TRSP_ARM_OR3       4'ha

`endif

// ==== verilog/trsp_result_port.v ====
// Purpose : channel-d arming select, four time-stamp fifos, result alu and
//           serial result port with generated result clock
// Assumes : capture stamps and arm flags come from logic on ref_clk
// Notes   : result clock is a divider of ref_clk; rates scale by 1:2:4
//           fifo reads happen only at the free-running load pulse
//
// Summary of operation
// (R1) arm select 0,1,2 makes channel d follow channel a, b or c; 11-15 reserved
// (R2) codes 3-6 need a&b, a&c, b&c or a&b&c fully armed
// (R3) codes 7-10: a|b, b|c, b|c, a|b|c
// (R4) software must avoid circular arming dependencies between channels
// (R5) each channel has its own fifo of 15 entries by 40 bits
// (R6) each channel shows full and empty flags
// (R7) captures are taken independently of the slower output rate
// (R8) on read the alu forms event minus sync plus calibration
// (R9) fifo reads are paced by the output shifter
// (R10) port is one shared clock, a strobe and data line per channel
// (R11) 3-bit length code selects 8,16,24,32 or 40 bit words
// (R12) length defaults to 40 bits after reset
// (R13) strobe low, marker bit, then bit 0 upward, sign bit last
// (R14) strobe high two bit times after the sign bit
// (R15) normal mode launches data on rising result clock edge
// (R16) receiver samples data and strobe on rising result clock edge
// (R17) double rate halves the clock and launches on both edges
// (R18) 2-bit clock select gives slow, double or quadruple rate
// (R19) reserved clock select code keeps the default rate
// (R20) frame is n data bits plus marker plus two gap bits
// (R21) captures into a full fifo are discarded
// (R22) free-running load pulse once per frame moves an entry to shifter
// (R23) load period follows word length and bit rate
// (R24) fifo to shifter takes five bit times before transmission
//
// The register offsets and strobed register access were chosen for this implementation.
`include "trsp_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module trsp_result_port (
  input  wire                      ref_clk,
  input  wire                      rstn,
  input  wire [`TRSP_AW-1:0]       reg_addr,
  input  wire [31:0]               reg_wdata,
  input  wire                      reg_wr,
  input  wire                      reg_rd,
  output reg  [31:0]               reg_rdata_ff,
  input  wire                      first_event_channel_armed,
  input  wire                      second_event_channel_armed,
  input  wire                      third_event_channel_armed,
  output reg                       fourth_arm_ok_ff,
  input  wire [3:0]                cap_valid,
  input  wire [4*`TRSP_W-1:0]      cap_stamp,
  input  wire [`TRSP_W-1:0]        sync_stamp,
  output reg                       rclk_ff,
  output reg  [3:0]                rstrobe_n_ff,
  output reg  [3:0]                rdata_ff
);

  // ========================================================================
  // functions
  function [5:0] word_bits;
    input [2:0] code;
    begin
      case (code)
        `TRSP_LEN_8:  word_bits = `TRSP_N_8;
        `TRSP_LEN_16: word_bits = `TRSP_N_16;
        `TRSP_LEN_24: word_bits = `TRSP_N_24;
        `TRSP_LEN_32: word_bits = `TRSP_N_32;
        default:      word_bits = `TRSP_N_40;
      endcase
    end
  endfunction

  function [3:0] bit_cycles;
    input [1:0] code;
    begin
      case (code)
        `TRSP_RATE_MID:  bit_cycles = `TRSP_BITC_MID;
        `TRSP_RATE_FAST: bit_cycles = `TRSP_BITC_FAST;
        default:         bit_cycles = `TRSP_BITC_SLOW; // R19
      endcase
    end
  endfunction

  function [5:0] mem_idx;
    input [1:0] ch;
    input [3:0] ptr;
    reg   [5:0] base;
    begin
      // each channel owns a run of fifo depth words in the shared array
      base    = {4'h0, ch} * `TRSP_DEPTH_IDX;
      mem_idx = base + {2'h0, ptr};
    end
  endfunction

  function [3:0] ptr_inc;
    input [3:0] ptr;
    begin
      ptr_inc = (ptr == `TRSP_PTR_LAST) ? 4'h0 : ptr + 4'h1;
    end
  endfunction

  function is_cal;
    input [`TRSP_AW-1:0] addr;
    begin
      is_cal = (addr >= `TRSP_ADDR_CAL0) && (addr <= `TRSP_ADDR_CAL3);
    end
  endfunction

  // ========================================================================
  // registers
  reg  [31:0]            ctrl_ff;
  reg  [`TRSP_CAL_W-1:0] cal_ff [0:3];
  wire [3:0]             full;
  wire [3:0]             empty;
  wire [3:0]             arm_sel = ctrl_ff[`TRSP_ARM_MSB:`TRSP_ARM_LSB];
  // calibration words are signed and added to every result
  wire                   cal_hit = is_cal(reg_addr);
  wire [`TRSP_AW-1:0]    cal_off = reg_addr - `TRSP_ADDR_CAL0;
  integer                i;

  always @(posedge ref_clk) begin
    if (!rstn) begin
      ctrl_ff <= `TRSP_CTRL_RST; // R12
      for (i = 0; i < 4; i = i + 1) begin
        cal_ff[i] <= {`TRSP_CAL_W{1'b0}};
      end
    end else if (reg_wr) begin
      if (reg_addr == `TRSP_ADDR_CTRL)
        ctrl_ff <= reg_wdata;
      if (cal_hit)
        cal_ff[cal_off[1:0]] <= reg_wdata[`TRSP_CAL_W-1:0];
    end
  end

  always @(posedge ref_clk) begin
    if (!rstn) begin
      reg_rdata_ff <= 32'h0;
    end else if (reg_rd) begin
      reg_rdata_ff <= 32'h0;
      if (reg_addr == `TRSP_ADDR_CTRL)
        reg_rdata_ff <= ctrl_ff;
      if (reg_addr == `TRSP_ADDR_STAT) begin
        reg_rdata_ff[`TRSP_ST_FULL_LSB+3:`TRSP_ST_FULL_LSB]   <= full;
        reg_rdata_ff[`TRSP_ST_EMPTY_LSB+3:`TRSP_ST_EMPTY_LSB] <= empty;
        reg_rdata_ff[`TRSP_ST_ARM_BIT] <= fourth_arm_ok_ff;
      end
      if (cal_hit)
        reg_rdata_ff[`TRSP_CAL_W-1:0] <= cal_ff[cal_off[1:0]];
    end else begin
      // read data stand one cycle, then the port returns to zero
      reg_rdata_ff <= 32'h0;
    end
  end

  // ========================================================================
  // channel d arming condition
  reg nxt_arm;
  wire aa = first_event_channel_armed;
  wire ab = second_event_channel_armed;
  wire ac = third_event_channel_armed;

  always @* begin
    case (arm_sel)
      4'h0: nxt_arm = aa; // R1
      4'h1: nxt_arm = ab; // R1
      4'h2: nxt_arm = ac; // R1
      4'h3: nxt_arm = aa & ab; // R2
      4'h4: nxt_arm = aa & ac; // R2
      4'h5: nxt_arm = ab & ac; // R2
      4'h6: nxt_arm = aa & ab & ac; // R2
      4'h7: nxt_arm = aa | ab; // R3
      4'h8: nxt_arm = ab | ac; // R3
      4'h9: nxt_arm = ab | ac; // R3
      `TRSP_ARM_OR3: nxt_arm = aa | ab | ac; // R3
      // reserved select codes keep channel d unarmed
      default: nxt_arm = 1'b0; // R1
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rstn)
      fourth_arm_ok_ff <= 1'b0;
    else
      fourth_arm_ok_ff <= nxt_arm;
  end

  // ========================================================================
  // bit timing and result clock
  reg  [3:0] cyc_ff;
  reg  [3:0] bitc_ff;
  reg        ddr_ff;
  reg  [5:0] n_ff;
  reg  [5:0] bit_idx_ff;
  wire       bit_end   = (cyc_ff == bitc_ff - 4'h1);
  wire [5:0] frame_end = n_ff + `TRSP_GAP_BITS;
  wire       wrap      = bit_end && (bit_idx_ff == frame_end); // R20
  wire       half_pt   = (cyc_ff == (bitc_ff >> 1) - 4'h1);
  // load five bit times ahead of the wrap so the alu result has settled
  wire       load      = bit_end &&
                         (bit_idx_ff == frame_end - `TRSP_LOAD_LEAD); // R24
  wire [5:0] nxt_idx   = wrap ? 6'h0 : bit_idx_ff + 6'h1;

  always @(posedge ref_clk) begin
    if (!rstn) begin
      cyc_ff     <= 4'h0;
      bit_idx_ff <= 6'h0;
      bitc_ff    <= `TRSP_BITC_SLOW;
      ddr_ff     <= 1'b0;
      n_ff       <= `TRSP_N_40; // R12
      rclk_ff    <= 1'b0;
    end else begin
      cyc_ff <= bit_end ? 4'h0 : cyc_ff + 4'h1;
      if (bit_end)
        bit_idx_ff <= nxt_idx;
      if (wrap) begin
        // settings only change on a frame boundary
        n_ff    <= word_bits(ctrl_ff[`TRSP_LEN_MSB:`TRSP_LEN_LSB]); // R11 R23
        bitc_ff <= bit_cycles(ctrl_ff[`TRSP_RATE_MSB:`TRSP_RATE_LSB]); // R18
        ddr_ff  <= ctrl_ff[`TRSP_DDR_BIT]; // R17
      end
      // rclk rises with each launched bit and falls mid-bit in normal mode; it toggles with each bit in double rate
      if (bit_end)
        rclk_ff <= ddr_ff ? ~rclk_ff : 1'b1; // R15 R17
      else if (!ddr_ff && half_pt)
        rclk_ff <= 1'b0;
    end
  end

  // ========================================================================
  // time-stamp fifos
  reg  [`TRSP_W-1:0] mem [0:4*`TRSP_DEPTH-1];
  reg  [3:0]         wptr_ff [0:3];
  reg  [3:0]         rptr_ff [0:3];
  reg  [4:0]         cnt_ff  [0:3];
  reg  [3:0]         wr_en;
  reg  [3:0]         rd_en;
  genvar             g;
  integer            fi;
  integer            mi;
  integer            pi;

  generate
    for (g = 0; g < 4; g = g + 1) begin : g_flag
      assign full[g]  = (cnt_ff[g] == `TRSP_CNT_FULL); // R6
      assign empty[g] = (cnt_ff[g] == 5'h0); // R6
    end
  endgenerate

  // a full fifo drops new captures; the read side is never held off
  always @* begin
    for (fi = 0; fi < 4; fi = fi + 1) begin
      wr_en[fi] = cap_valid[fi] & ~full[fi]; // R21 R7
      rd_en[fi] = load & ~empty[fi]; // R9 R22
    end
  end

  always @(posedge ref_clk) begin
    for (mi = 0; mi < 4; mi = mi + 1) begin
      if (wr_en[mi])
        mem[mem_idx(mi[1:0], wptr_ff[mi])] <=
          cap_stamp[mi*`TRSP_W +: `TRSP_W]; // R5
    end
  end

  always @(posedge ref_clk) begin
    for (pi = 0; pi < 4; pi = pi + 1) begin
      if (!rstn) begin
        wptr_ff[pi] <= 4'h0;
        rptr_ff[pi] <= 4'h0;
        cnt_ff[pi]  <= 5'h0;
      end else begin
        if (wr_en[pi])
          wptr_ff[pi] <= ptr_inc(wptr_ff[pi]);
        if (rd_en[pi])
          rptr_ff[pi] <= ptr_inc(rptr_ff[pi]);
        cnt_ff[pi] <= cnt_ff[pi] + {4'h0, wr_en[pi]} - {4'h0, rd_en[pi]};
      end
    end
  end

  // ========================================================================
  // alu and shifter
  reg  [`TRSP_W-1:0] pend_res_ff [0:3];
  reg  [3:0]         pend_val_ff;
  reg  [`TRSP_W-1:0] sh_res_ff [0:3];
  reg  [3:0]         sh_val_ff;
  reg  [3:0]         nxt_strobe_n;
  reg  [3:0]         nxt_data;
  integer            ai;
  integer            oi;

  always @(posedge ref_clk) begin
    for (ai = 0; ai < 4; ai = ai + 1) begin
      if (!rstn) begin
        pend_val_ff[ai] <= 1'b0;
        pend_res_ff[ai] <= {`TRSP_W{1'b0}};
        sh_val_ff[ai]   <= 1'b0;
        sh_res_ff[ai]   <= {`TRSP_W{1'b0}};
      end else begin
        if (load) begin
          pend_val_ff[ai] <= rd_en[ai]; // R22
          pend_res_ff[ai] <= mem[mem_idx(ai[1:0], rptr_ff[ai])] - sync_stamp
            + {{(`TRSP_W-`TRSP_CAL_W){cal_ff[ai][`TRSP_CAL_W-1]}},
               cal_ff[ai]}; // R8
        end
        if (wrap) begin
          sh_val_ff[ai] <= pend_val_ff[ai];
          sh_res_ff[ai] <= pend_res_ff[ai];
        end
      end
    end
  end

  // frame: idx 0 marker, 1..n-1 data lsb first, n sign, n+1..n+2 gap
  always @* begin
    for (oi = 0; oi < 4; oi = oi + 1) begin
      nxt_strobe_n[oi] = 1'b1;
      nxt_data[oi]     = 1'b0;
      if ((wrap ? pend_val_ff[oi] : sh_val_ff[oi]) && nxt_idx <= n_ff) begin
        nxt_strobe_n[oi] = 1'b0; // R13
        if (nxt_idx == 6'h0)
          nxt_data[oi] = 1'b1; // R13
        else if (nxt_idx == n_ff)
          nxt_data[oi] = sh_res_ff[oi][`TRSP_W-1]; // R13 R20
        else
          nxt_data[oi] = sh_res_ff[oi][nxt_idx - 6'h1]; // R13
      end
    end
  end

  // outputs move only on bit boundaries, together with the rclk edge
  always @(posedge ref_clk) begin
    if (!rstn) begin
      rstrobe_n_ff <= 4'hf;
      rdata_ff     <= 4'h0;
    end else if (bit_end) begin
      rstrobe_n_ff <= nxt_strobe_n; // R10 R14
      rdata_ff     <= nxt_data; // R15
    end
  end

endmodule // trsp_result_port

`default_nettype wire
